// ===== shared/ssor_params.svh
`ifndef SSOR_PARAMS_SVH
`define SSOR_PARAMS_SVH

// ****************************************************************
// Widths and counts
// ****************************************************************
`define SSOR_CODE_W    6
`define SSOR_NFUNC     64
`define SSOR_VAL_W     16
`define SSOR_MENU_W    4
`define SSOR_N_ALARM   4
`define SSOR_N_RANGE   4
`define SSOR_N_SENS    3
`define SSOR_N_EXT     2
`define SSOR_N_ZERO    2
`define SSOR_N_TEST    4
`define SSOR_N_REL     5
`define SSOR_N_TRN     8
`define SSOR_N_PIN     2
`define SSOR_PIN_WARM  0
`define SSOR_PIN_COND  1

// ****************************************************************
// Menu levels that force the service state
// ****************************************************************
`define SSOR_MENU_LVL_A 4'h6
`define SSOR_MENU_LVL_B 4'h7

// ****************************************************************
// Switch function codes; code 0 is a function that is never active
// ****************************************************************
`define SSOR_F_NONE    0
`define SSOR_F_FAIL    1
`define SSOR_F_SERV    2
`define SSOR_F_FAULT   3
`define SSOR_F_ALARM0  4
`define SSOR_F_CAL     8
`define SSOR_F_AUTO    9
`define SSOR_F_RANGE0  10
`define SSOR_F_SFAIL0  14
`define SSOR_F_EFAIL0  17
`define SSOR_F_SSERV0  19
`define SSOR_F_ESERV0  22
`define SSOR_F_SCAL0   24
`define SSOR_F_ECAL0   27
`define SSOR_F_FLOW    29
`define SSOR_F_COND    30
`define SSOR_F_ZERO0   31
`define SSOR_F_TEST0   33
`define SSOR_F_PUMP    37

`endif

// ===== shared/ssor_pkg.sv
`include "ssor_params.svh"

package ssor_pkg;

  // ****************************************************************
  // Configuration of one assignable output
  // ****************************************************************
  typedef struct packed {
    logic [`SSOR_CODE_W-1:0] code;
    logic                    inv;
  } ssor_cfg_t;

  // ****************************************************************
  // Internal conditions from the instrument, same clock
  // ****************************************************************
  typedef struct packed {
    logic                     internal_fault;
    logic                     maint_req;
    logic [`SSOR_MENU_W-1:0]  menu_level;
    logic                     cal_running;
    logic                     auto_cal;
    logic                     limit_exceeded;
    logic [`SSOR_N_RANGE-1:0] range_first;
    logic [`SSOR_N_SENS-1:0]  sens_fail;
    logic [`SSOR_N_SENS-1:0]  sens_serv;
    logic [`SSOR_N_SENS-1:0]  sens_cal;
    logic [`SSOR_N_EXT-1:0]   ext_fail;
    logic [`SSOR_N_EXT-1:0]   ext_serv;
    logic [`SSOR_N_EXT-1:0]   ext_cal;
    logic [`SSOR_N_ZERO-1:0]  zero_req;
    logic [`SSOR_N_TEST-1:0]  test_req;
    logic                     pump_req;
  } ssor_cond_t;

  // ****************************************************************
  // Alarm channels: value, limit and direction
  // ****************************************************************
  typedef struct packed {
    logic [`SSOR_N_ALARM-1:0][`SSOR_VAL_W-1:0] value;
    logic [`SSOR_N_ALARM-1:0][`SSOR_VAL_W-1:0] limit;
    logic [`SSOR_N_ALARM-1:0]                  above;
  } ssor_alarm_t;

endpackage : ssor_pkg

// ===== rtl/ssor_sync.sv
`include "ssor_params.svh"

module ssor_sync (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_n,
  // Pins
  input  wire logic [`SSOR_N_PIN-1:0]  i_pin,
  // Filtered levels
  output logic      [`SSOR_N_PIN-1:0]  o_level
);
  import ssor_pkg::*;

  logic [`SSOR_N_PIN-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [`SSOR_N_PIN-1:0] s1_d, s2_d, s3_d, lvl_d;

  // A level is taken once the second and third stages agree.
  always_comb begin
    s1_d  = i_rst_n ? i_pin : '0;
    s2_d  = i_rst_n ? s1_q : '0;
    s3_d  = i_rst_n ? s2_q : '0;
    lvl_d = lvl_q;
    for (int i = 0; i < `SSOR_N_PIN; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
    if (!i_rst_n) begin
      lvl_d = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    s1_q  <= s1_d;
    s2_q  <= s2_d;
    s3_q  <= s3_d;
    lvl_q <= lvl_d;
  end

  assign o_level = lvl_q;

endmodule : ssor_sync

// ===== rtl/ssor_slot.sv
`include "ssor_params.svh"

module ssor_slot (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_n,
  // Function flags and configuration
  input  wire logic [`SSOR_NFUNC-1:0]  i_flags,
  input  ssor_pkg::ssor_cfg_t          i_cfg,
  // Switch output
  output logic                         o_out
);
  import ssor_pkg::*;

  logic out_q, out_d;

  always_comb begin
    out_d = i_rst_n ? (i_flags[i_cfg.code] ^ i_cfg.inv) : 1'b0;
  end

  always_ff @(posedge i_ref_clk) begin
    out_q <= out_d;
  end

  assign o_out = out_q;

  a_slot_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_out == ($past(i_flags[i_cfg.code]) ^ $past(i_cfg.inv)))
    else $error("Switch output does not follow its function and inversion.");

endmodule : ssor_slot

// ===== rtl/ssor_router.sv
// Operation
// - Gas and pump requests wait for warm-up.
// - Failure raised on internal fault.
// - Failure relay energised only without failure.
// - Failure, service, fault own dedicated relays.
// - Service on calibration, maintenance, menu six/seven.
// - Fault on slight internal limit excess.
// - Four alarm flags, value beyond limit.
// - Calibration flag and automatic calibration flag.
// - Range flag while output in range one.
// - Per-sensor failure, service, calibration flags.
// - Flow flag below half the limit.
// - Condensate flag while condensate detected.
// - Zero, test gas and pump request flags.
// - Five relays, eight transistors select codes.
// - Per-output inversion option.
// - Inverted output opposes its function.
// - One function drives many outputs independently.
`include "ssor_params.svh"

module ssor_router (
  // Clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst_n,
  // Pins from the instrument
  input  wire logic                       i_warm_pin,
  input  wire logic                       i_condensate_pin,
  // Internal conditions
  input  ssor_pkg::ssor_cond_t            i_cond,
  input  ssor_pkg::ssor_alarm_t           i_alarm,
  input  wire logic [`SSOR_VAL_W-1:0]     i_flow,
  input  wire logic [`SSOR_VAL_W-1:0]     i_flow_limit,
  // Output assignment
  input  ssor_pkg::ssor_cfg_t [`SSOR_N_REL-1:0] i_relay_cfg,
  input  ssor_pkg::ssor_cfg_t [`SSOR_N_TRN-1:0] i_trans_cfg,
  // Dedicated relays
  output logic                            o_dedicated_relay_a,
  output logic                            o_dedicated_relay_b,
  output logic                            o_dedicated_relay_c,
  // Assignable outputs
  output logic [`SSOR_N_REL-1:0]          o_assignable_relay,
  output logic [`SSOR_N_TRN-1:0]          o_transistor_out,
  // Status
  output logic                            o_warm
);
  import ssor_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic alarm_hit(input logic [`SSOR_VAL_W-1:0] v,
                                     input logic [`SSOR_VAL_W-1:0] l,
                                     input logic                   above);
    alarm_hit = above ? (v > l) : (v < l);
  endfunction : alarm_hit

  function automatic logic is_service_menu(input logic [`SSOR_MENU_W-1:0] lvl);
    is_service_menu = (lvl == `SSOR_MENU_LVL_A) || (lvl == `SSOR_MENU_LVL_B);
  endfunction : is_service_menu

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [`SSOR_N_PIN-1:0] pin_lvl;

  ssor_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     ({i_condensate_pin, i_warm_pin}),
    .o_level   (pin_lvl)
  );

  // ****************************************************************
  // Warm-up latch
  // ****************************************************************
  logic warm_q, warm_d;

  // Once reached, the operating temperature stays reached until reset.
  always_comb begin
    warm_d = i_rst_n ? (warm_q | pin_lvl[`SSOR_PIN_WARM]) : 1'b0;
  end

  always_ff @(posedge i_ref_clk) begin
    warm_q <= warm_d;
  end

  assign o_warm = warm_q;

  // ****************************************************************
  // Function flags
  // ****************************************************************
  logic [`SSOR_NFUNC-1:0]  flags;
  logic [`SSOR_VAL_W:0]    flow_x2;

  always_comb begin
    flow_x2 = {i_flow, 1'b0};
    flags   = '0;
    flags[`SSOR_F_FAIL]  = i_cond.internal_fault;
    flags[`SSOR_F_SERV]  = i_cond.cal_running | i_cond.maint_req
                         | is_service_menu(i_cond.menu_level);
    flags[`SSOR_F_FAULT] = i_cond.limit_exceeded;
    flags[`SSOR_F_CAL]   = i_cond.cal_running;
    flags[`SSOR_F_AUTO]  = i_cond.auto_cal;
    flags[`SSOR_F_FLOW]  = flow_x2 < {1'b0, i_flow_limit};
    flags[`SSOR_F_COND]  = pin_lvl[`SSOR_PIN_COND];
    flags[`SSOR_F_PUMP]  = warm_q & i_cond.pump_req;
    for (int i = 0; i < `SSOR_N_ALARM; i++) begin
      flags[`SSOR_F_ALARM0 + i] = alarm_hit(i_alarm.value[i], i_alarm.limit[i],
                                            i_alarm.above[i]);
    end
    for (int i = 0; i < `SSOR_N_RANGE; i++) begin
      flags[`SSOR_F_RANGE0 + i] = i_cond.range_first[i];
    end
    for (int i = 0; i < `SSOR_N_SENS; i++) begin
      flags[`SSOR_F_SFAIL0 + i] = i_cond.sens_fail[i];
      flags[`SSOR_F_SSERV0 + i] = i_cond.sens_serv[i];
      flags[`SSOR_F_SCAL0 + i]  = i_cond.sens_cal[i];
    end
    for (int i = 0; i < `SSOR_N_EXT; i++) begin
      flags[`SSOR_F_EFAIL0 + i] = i_cond.ext_fail[i];
      flags[`SSOR_F_ESERV0 + i] = i_cond.ext_serv[i];
      flags[`SSOR_F_ECAL0 + i]  = i_cond.ext_cal[i];
    end
    for (int i = 0; i < `SSOR_N_ZERO; i++) begin
      flags[`SSOR_F_ZERO0 + i] = warm_q & i_cond.zero_req[i];
    end
    for (int i = 0; i < `SSOR_N_TEST; i++) begin
      flags[`SSOR_F_TEST0 + i] = warm_q & i_cond.test_req[i];
    end
  end

  // ****************************************************************
  // Dedicated relays
  // ****************************************************************
  logic [2:0] ded_q, ded_d;

  // The failure relay works on the closed-circuit principle.
  always_comb begin
    ded_d = i_rst_n ? {flags[`SSOR_F_FAULT], flags[`SSOR_F_SERV],
                       ~flags[`SSOR_F_FAIL]} : 3'h0;
  end

  always_ff @(posedge i_ref_clk) begin
    ded_q <= ded_d;
  end

  assign o_dedicated_relay_a = ded_q[0];
  assign o_dedicated_relay_b = ded_q[1];
  assign o_dedicated_relay_c = ded_q[2];

  // ****************************************************************
  // Assignable outputs
  // ****************************************************************
  for (genvar g = 0; g < `SSOR_N_REL; g++) begin : g_rel
    ssor_slot u_slot (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_flags   (flags),
      .i_cfg     (i_relay_cfg[g]),
      .o_out     (o_assignable_relay[g])
    );
  end

  for (genvar g = 0; g < `SSOR_N_TRN; g++) begin : g_trn
    ssor_slot u_slot (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_flags   (flags),
      .i_cfg     (i_trans_cfg[g]),
      .o_out     (o_transistor_out[g])
    );
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_cold_no_req: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !warm_q |-> !flags[`SSOR_F_PUMP] && !flags[`SSOR_F_ZERO0] && !flags[`SSOR_F_TEST0])
    else $error("Control request active before warm-up.");

  a_fail_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_cond.internal_fault |-> flags[`SSOR_F_FAIL])
    else $error("Failure flag missing on internal fault.");

  a_fail_relay_open: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_dedicated_relay_a == !$past(i_cond.internal_fault))
    else $error("Failure relay not closed-circuit.");

  a_ded_relays: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(i_cond.limit_exceeded) && $past(i_rst_n) |=> o_dedicated_relay_c)
    else $error("Fault relay did not follow fault.");

  a_service_menu: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cond.menu_level == `SSOR_MENU_LVL_B) ##1 i_rst_n |-> o_dedicated_relay_b)
    else $error("Service relay idle in menu level seven.");

  a_alarm_first: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_alarm.above[0] && i_alarm.value[0] > i_alarm.limit[0]) |-> flags[`SSOR_F_ALARM0])
    else $error("Alarm flag missing above limit.");

  a_auto_cal: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    flags[`SSOR_F_AUTO] == i_cond.auto_cal && flags[`SSOR_F_CAL] == i_cond.cal_running)
    else $error("Calibration flags wrong.");

  a_flow_half: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_flow_limit > 16'h0001 && i_flow == (i_flow_limit >> 1) && !i_flow_limit[0])
      |-> !flags[`SSOR_F_FLOW])
    else $error("Flow flag set at exactly half the limit.");

  a_same_code: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_relay_cfg[0] == i_trans_cfg[0]) ##1 $past(i_rst_n)
      |-> o_assignable_relay[0] == o_transistor_out[0])
    else $error("Outputs sharing a function disagree.");

endmodule : ssor_router

// ===== test/ssor_plant.sv
`include "ssor_params.svh"

module ssor_plant (
  // Contacts from the block
  input  wire logic                   i_relay_a,
  input  wire logic                   i_relay_b,
  input  wire logic                   i_relay_c,
  input  wire logic [`SSOR_N_REL-1:0] i_relay,
  input  wire logic [`SSOR_N_TRN-1:0] i_trans,
  // Energised loads, one bit per contact
  output logic      [15:0]            o_load
);
  timeunit 1ns;
  timeprecision 100ps;
  // Make contacts only: a load runs exactly while its contact is energised.
  assign o_load = {i_trans, i_relay, i_relay_c, i_relay_b, i_relay_a};
endmodule : ssor_plant

// ===== test/ssor_router_tb_top.sv
`include "ssor_params.svh"

module ssor_router_tb_top import ssor_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic                        clk;
  logic                        rst_n;
  logic                        warm_pin;
  logic                        cond_pin;
  ssor_cond_t                  cond;
  ssor_alarm_t                 alarm;
  logic [`SSOR_VAL_W-1:0]      flow;
  logic [`SSOR_VAL_W-1:0]      flow_lim;
  ssor_cfg_t [`SSOR_N_REL-1:0] rcfg;
  ssor_cfg_t [`SSOR_N_TRN-1:0] tcfg;
  logic                        ra;
  logic                        rb;
  logic                        rc;
  logic                        warm;
  logic [`SSOR_N_REL-1:0]      rel;
  logic [`SSOR_N_TRN-1:0]      trn;
  logic [15:0]                 load;
  logic                        warm_exp;
  logic                        cond_exp;
  int                          n_fail = 0;
  int                          samples_checked = 0;
  int                          cyc = 0;

  ssor_router DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_warm_pin(warm_pin),
    .i_condensate_pin(cond_pin), .i_cond(cond), .i_alarm(alarm), .i_flow(flow),
    .i_flow_limit(flow_lim), .i_relay_cfg(rcfg), .i_trans_cfg(tcfg),
    .o_dedicated_relay_a(ra), .o_dedicated_relay_b(rb), .o_dedicated_relay_c(rc),
    .o_assignable_relay(rel), .o_transistor_out(trn), .o_warm(warm));
  ssor_plant plant (.i_relay_a(ra), .i_relay_b(rb), .i_relay_c(rc), .i_relay(rel),
    .i_trans(trn), .o_load(load));

  // ****************************************************************
  // Expected switch functions
  // ****************************************************************
  function automatic logic expf(input int c);
    logic [`SSOR_N_ALARM-1:0] al;
    for (int k = 0; k < `SSOR_N_ALARM; k++) begin
      al[k] = alarm.above[k] ? (alarm.value[k] > alarm.limit[k])
                             : (alarm.value[k] < alarm.limit[k]);
    end
    case (c) inside
      `SSOR_F_FAIL:                      return cond.internal_fault;
      `SSOR_F_SERV:                      return cond.cal_running | cond.maint_req |
        (cond.menu_level inside {`SSOR_MENU_LVL_A, `SSOR_MENU_LVL_B});
      `SSOR_F_FAULT:                     return cond.limit_exceeded;
      [`SSOR_F_ALARM0:`SSOR_F_CAL-1]:    return al[c-`SSOR_F_ALARM0];
      `SSOR_F_CAL:                       return cond.cal_running;
      `SSOR_F_AUTO:                      return cond.auto_cal;
      [`SSOR_F_RANGE0:`SSOR_F_SFAIL0-1]: return cond.range_first[c-`SSOR_F_RANGE0];
      [`SSOR_F_SFAIL0:`SSOR_F_EFAIL0-1]: return cond.sens_fail[c-`SSOR_F_SFAIL0];
      [`SSOR_F_EFAIL0:`SSOR_F_SSERV0-1]: return cond.ext_fail[c-`SSOR_F_EFAIL0];
      [`SSOR_F_SSERV0:`SSOR_F_ESERV0-1]: return cond.sens_serv[c-`SSOR_F_SSERV0];
      [`SSOR_F_ESERV0:`SSOR_F_SCAL0-1]:  return cond.ext_serv[c-`SSOR_F_ESERV0];
      [`SSOR_F_SCAL0:`SSOR_F_ECAL0-1]:   return cond.sens_cal[c-`SSOR_F_SCAL0];
      [`SSOR_F_ECAL0:`SSOR_F_FLOW-1]:    return cond.ext_cal[c-`SSOR_F_ECAL0];
      `SSOR_F_FLOW:                      return (int'(flow) * 2) < int'(flow_lim);
      `SSOR_F_COND:                      return cond_exp;
      [`SSOR_F_ZERO0:`SSOR_F_TEST0-1]:   return warm_exp & cond.zero_req[c-`SSOR_F_ZERO0];
      [`SSOR_F_TEST0:`SSOR_F_PUMP-1]:    return warm_exp & cond.test_req[c-`SSOR_F_TEST0];
      `SSOR_F_PUMP:                      return warm_exp & cond.pump_req;
      default:                           return 1'b0;
    endcase
  endfunction : expf

  // ****************************************************************
  // Shared checks and drivers
  // ****************************************************************
  task automatic cmp(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %b expected %b", $time, got, exp);
    end
  endtask : cmp

  task automatic check_all();
    repeat (8) @(posedge clk);
    #1;
    cmp(load[0], ~expf(`SSOR_F_FAIL));
    cmp(load[1], expf(`SSOR_F_SERV));
    cmp(load[2], expf(`SSOR_F_FAULT));
    for (int i = 0; i < `SSOR_N_REL; i++) begin
      cmp(load[3+i], expf(rcfg[i].code) ^ rcfg[i].inv);
    end
    for (int i = 0; i < `SSOR_N_TRN; i++) begin
      cmp(load[8+i], expf(tcfg[i].code) ^ tcfg[i].inv);
    end
    cmp(warm, warm_exp);
  endtask : check_all

  task automatic set_slots(input int base, input logic inv0);
    @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      if (i < `SSOR_N_REL) begin
        rcfg[i] <= '{code: 6'(base + i), inv: inv0 ^ i[0]};
      end else begin
        tcfg[i-`SSOR_N_REL] <= '{code: 6'(base + i), inv: inv0 ^ i[0]};
      end
    end
  endtask : set_slots

  task automatic t_codes();
    ssor_cond_t pats [4];
    pats = '{'0, '1, ssor_cond_t'(35'h555555555), ssor_cond_t'(35'h2aaaaaaaa)};
    for (int b = 0; b < 39; b += 13) begin
      for (int iv = 0; iv < 2; iv++) begin
        for (int p = 0; p < 4; p++) begin
          set_slots(b, iv[0]);
          cond <= pats[p];
          check_all();
        end
      end
    end
    $display("test codes done, warm %b", warm_exp);
  endtask : t_codes

  task automatic t_service();
    ssor_cond_t c;
    for (int lv = 5; lv < 9; lv++) begin
      c = '0;
      c.menu_level = 4'(lv);
      @(posedge clk);
      cond <= c;
      check_all();
    end
    $display("test service done");
  endtask : t_service

  task automatic t_alarm();
    ssor_alarm_t a;
    set_slots(`SSOR_F_ALARM0, 1'b0);
    for (int r = 0; r < 2; r++) begin
      a.value = {16'h8001, 16'h7fff, 16'h8000, 16'h8001};
      a.limit = {4{16'h8000}};
      a.above = r ? 4'hc : 4'h3;
      @(posedge clk);
      alarm <= a;
      check_all();
    end
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_flow();
    set_slots(`SSOR_F_FLOW, 1'b0);
    flow_lim <= 16'h0064;
    flow <= 16'h0031;
    cond_pin <= 1'b1;
    cond_exp = 1'b1;
    check_all();
    @(posedge clk);
    flow <= 16'h0032;
    cond_pin <= 1'b0;
    cond_exp = 1'b0;
    check_all();
    $display("test flow done");
  endtask : t_flow

  task automatic t_latency();
    set_slots(`SSOR_F_FAIL, 1'b0);
    cond <= '0;
    check_all();
    @(posedge clk);
    cond.internal_fault <= 1'b1;
    #1;
    cmp(load[0], 1'b1);
    @(posedge clk);
    #1;
    cmp(load[0], 1'b0);
    cmp(load[3], 1'b1);
    cmp(load[4], 1'b1);
    $display("test latency done");
  endtask : t_latency

  task automatic t_shared();
    ssor_cfg_t [`SSOR_N_TRN-1:0] t;
    ssor_cond_t                  c;
    for (int r = 0; r < 2; r++) begin
      t = {`SSOR_N_TRN{7'h06}};
      t[1].inv = 1'b1;
      c = '0;
      c.limit_exceeded = r[0];
      @(posedge clk);
      rcfg <= {`SSOR_N_REL{7'h06}};
      tcfg <= t;
      cond <= c;
      check_all();
    end
    $display("test shared done");
  endtask : t_shared

  task automatic t_warm();
    @(posedge clk);
    warm_pin <= 1'b1;
    warm_exp = 1'b1;
    t_codes();
    @(posedge clk);
    warm_pin <= 1'b0;
    check_all();
    $display("test warm done");
  endtask : t_warm

  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    cmp(|load, 1'b0);
    cmp(warm, 1'b0);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    warm_exp = 1'b0;
    set_slots(`SSOR_F_ZERO0, 1'b0);
    cond <= '1;
    check_all();
    $display("test reset done");
  endtask : t_reset

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    rst_n = 1'b0;
    warm_pin = 1'b0;
    cond_pin = 1'b0;
    cond = '1;
    alarm = '0;
    flow = '0;
    flow_lim = '0;
    rcfg = {`SSOR_N_REL{7'h02}};
    tcfg = {`SSOR_N_TRN{7'h03}};
    warm_exp = 1'b0;
    cond_exp = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    cmp(|load, 1'b0);
    @(posedge clk);
    rst_n <= 1'b1;
    t_latency();
    t_codes();
    t_service();
    t_alarm();
    t_flow();
    t_shared();
    t_warm();
    t_reset();
    tally_and_finish();
  end
endmodule : ssor_router_tb_top
